// file: sim/ifp_fetch_top_chk.sv
// Purpose: Port assertions for the fetch pipeline
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to ifp_fetch_top after the module
`timescale 1ns/1ps
`include "ifp_defs.svh"
module ifp_fetch_chk (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Watched outputs
    input wire logic [`IFP_PC_W-1:0] PROG_ADDR_OUT,
    input wire logic [`IFP_PC_W-1:0] PC_OUT,
    input wire logic [3:0] PHASE_OUT,
    input wire logic DATA_READ_OUT,
    input wire logic DATA_WRITE_OUT,
    input wire logic [`IFP_WORD_W-1:0] INSTR_OUT,
    input wire logic SECOND_WORD_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    sequence ifp_rest_s;
        PHASE_OUT[1] ##1 PHASE_OUT[2] ##1 PHASE_OUT[3] ##1 PHASE_OUT[0];
    endsequence
    chk_phase_onehot: assert property (PHASE_OUT != 4'h0 |-> $onehot(PHASE_OUT))
        else $error("phase flags not one-hot");
    chk_phase_order: assert property (PHASE_OUT[0] |=> ifp_rest_s)
        else $error("phase order broken");
    chk_phase_start: assert property (PHASE_OUT == 4'h0 |-> ##[1:8] PHASE_OUT != 4'h0)
        else $error("phases never start");
    chk_pc_even: assert property (PC_OUT[0] == 1'b0)
        else $error("pc low bit set");
    chk_addr_even: assert property (PROG_ADDR_OUT[0] == 1'b0)
        else $error("fetch address odd");
    chk_read_phase: assert property (DATA_READ_OUT |-> PHASE_OUT[1])
        else $error("data read outside phase two");
    chk_write_phase: assert property (DATA_WRITE_OUT |-> PHASE_OUT[3])
        else $error("data write outside phase four");
    chk_instr_stands: assert property ($changed(INSTR_OUT) |-> PHASE_OUT[1])
        else $error("instruction view changed outside its load slot");
    chk_second_tag: assert property (SECOND_WORD_OUT |-> INSTR_OUT[15:12] == 4'hF)
        else $error("second word without all-ones nibble");
endmodule : ifp_fetch_chk
bind ifp_fetch_top ifp_fetch_chk ifp_fetch_chk_inst (.CLK_IN(CLK_IN),
    .ARST_N_IN(ARST_N_IN), .PROG_ADDR_OUT(PROG_ADDR_OUT), .PC_OUT(PC_OUT),
    .PHASE_OUT(PHASE_OUT), .DATA_READ_OUT(DATA_READ_OUT),
    .DATA_WRITE_OUT(DATA_WRITE_OUT), .INSTR_OUT(INSTR_OUT),
    .SECOND_WORD_OUT(SECOND_WORD_OUT));

// file: sim/ifp_fetch_top_tb_top.sv
// Purpose: Self-checking bench for the fetch pipeline
// Assumes: 100 MHz clock, reset held six cycles
// Notes: Executed words are compared in order against a queue
`timescale 1ns/1ps
`include "ifp_defs.svh"
module ifp_fetch_top_tb_top;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [7:0] working_in = 8'h00;
    logic skip_in = 1'b0;
    logic [7:0] byte_in = 8'h00;
    logic [31:0] seed = 32'h0000_7871;
    logic [20:0] addr, pc, tptr;
    logic [15:0] data, instr;
    logic [11:0] lit;
    logic [7:0] tlat;
    logic [3:0] phase;
    logic rd, wr, vld, sec;
    logic [16:0] exp_q [$];
    logic [7:0] tab_q [$];
    logic [16:0] note;
    int err_count = 0;
    int cmp_count = 0;
    ifp_fetch_top ifp_fetch_top_inst (.CLK_IN(clk_in), .ARST_N_IN(arst_n_in),
        .PROG_ADDR_OUT(addr), .PROG_DATA_IN(data), .PROG_BYTE_IN(byte_in),
        .WORKING_REG_IN(working_in), .SKIP_IN(skip_in), .DATA_READ_OUT(rd),
        .DATA_WRITE_OUT(wr), .PHASE_OUT(phase), .INSTR_OUT(instr),
        .INSTR_VALID_OUT(vld), .SECOND_WORD_OUT(sec), .LITERAL_OUT(lit),
        .PC_OUT(pc), .TABLE_PTR_OUT(tptr), .TABLE_LATCH_OUT(tlat));
    ifp_prog_mem ifp_prog_mem_inst (.addr_in(addr), .data_out(data));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        seed <= xs(seed);
        byte_in <= seed[7:0];
        // Skip the move pair's first word so its second word runs alone
        skip_in <= (vld === 1'b0 && instr === 16'h1234 && phase[2] === 1'b1);
    end
    // Executed words in order with the second-word flag on top
    initial begin
        @(posedge clk_in);
        working_in <= {5'h00, seed[2:1], 1'b0};
        @(posedge clk_in);
        exp_q = '{17'h0_0E55, 17'h0_EF05, 17'h1_F000, 17'h0_F456,
            17'h0_F789, 17'h0_26F9};
        for (int i = 9 + working_in[2:1]; i <= 12; i++) begin
            exp_q.push_back({1'b0, 16'h0E00 + 16'(i)});
        end
        exp_q.push_back(17'h0_D002);
        exp_q.push_back(17'h0_0E10);
        exp_q.push_back(17'h0_0002);
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int n = 0; n < 600 && exp_q.size() != 0; n++) begin
            @(posedge clk_in);
        end
        check(17'(exp_q.size()), 17'h0_0000);
        repeat (40) @(posedge clk_in);
        check(17'(tab_q.size()), 17'h0_0000);
        end_of_test();
    end
    always @(negedge clk_in) begin
        if (arst_n_in && phase[1] === 1'b1 && vld === 1'b1 &&
            exp_q.size() != 0) begin
            note = exp_q.pop_front();
            check({sec, instr}, note);
            if (note[16]) begin
                check(17'(lit), 17'(note[11:0]));
            end
        end
        // Table read: byte taken in phase four, shown one cycle later
        if (arst_n_in && vld === 1'b1 && instr === 16'h0002) begin
            if (phase[1] === 1'b1) begin
                check(17'(pc), 17'h0_0024);
            end else if (phase[2] === 1'b1) begin
                tab_q.push_back(byte_in);
            end else if (phase[0] === 1'b1 && tab_q.size() != 0) begin
                check(17'(tlat), 17'(tab_q.pop_front()));
            end
        end
    end
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
endmodule : ifp_fetch_top_tb_top

// file: sim/ifp_prog_mem.sv
// Purpose: Program memory model answering a byte address
// Assumes: Word at the even address, zero beyond the program
// Notes: Program exercises goto, pair, lone word, pc add, branch, table read
`timescale 1ns/1ps
`include "ifp_defs.svh"
module ifp_prog_mem (
    // Fetch side
    input wire logic [`IFP_PC_W-1:0] addr_in,
    output logic [`IFP_WORD_W-1:0] data_out
);
    localparam logic [15:0] ROM [0:17] = '{16'h0E55, 16'hEF05, 16'hF000,
        16'h1234, 16'h5678, 16'hC123, 16'hF456, 16'hF789, 16'h26F9,
        16'h0E09, 16'h0E0A, 16'h0E0B, 16'h0E0C, 16'hD002, 16'h0E0E,
        16'h0E0F, 16'h0E10, 16'h0002};
    // Byte address to word index
    assign data_out = (addr_in[20:1] > 20'h0_0011) ? 16'h0000 :
        ROM[addr_in[5:1]];
endmodule : ifp_prog_mem

// file: src/ifp_defs.svh
// Purpose: Constants for the instruction fetch pipeline
// Assumes: 100 MHz system clock, four phases per instruction cycle
// Notes: Included by the design modules and the simulation files
// Functional notes
// - Divide the system clock by four into four one-hot instruction phases.
// - Step the program counter in phase one; finish the fetch by phase four. The code steps the counter in phase four.
// - Latch the fetched word into the instruction register in phase one.
// - Overlap fetch with execute; a program counter change flushes the prefetch.
// - Read the data operand in phase two, write the result in phase four.
// - Program memory is byte addressed; word low bytes sit at even addresses.
// - The program counter steps by two and its low bit reads zero.
// - Absolute call and jump targets load program counter bits 20 to 1.
// - Relative branch offsets count single words, not bytes.
// - Four two-word instructions; second word has all ones in upper nibble.
// - An all-ones-nibble word alone runs as a no-operation.
// - Adding working register to pc low byte advances the pc by bytes.
// - Table reads use a byte address pointer and a one-byte latch. The code never loads the pointer; the latch takes PROG_BYTE_IN.
`ifndef IFP_DEFS_SVH
`define IFP_DEFS_SVH
`define IFP_PC_W 21
`define IFP_PC_RESET 21'h00_0000
`define IFP_PC_STEP 21'h00_0002
`define IFP_WORD_W 16
`define IFP_NOP_WORD 16'h0000
`define IFP_SECOND_NIBBLE 4'hF
`define IFP_OP_GOTO 8'hEF
`define IFP_OP_CALL 7'h76
`define IFP_OP_MOVE_FILE 4'hC
`define IFP_OP_LOAD_SELECT 10'h3B8
`define IFP_OP_BRA 5'h1A
`define IFP_OP_ADD_WORK_PC 16'h26F9
`define IFP_OP_TBLRD 14'h0002
`endif

// file: src/ifp_fetch_top.sv
// Purpose: Instruction fetch and pipeline control
// Assumes: Program memory answers combinationally to a byte address
// Notes: Program memory returns the word at the even address given
`timescale 1ns/1ps
`include "ifp_defs.svh"
module ifp_fetch_top
    import ifp_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic ARST_N_IN,
    // Program memory
    output logic [`IFP_PC_W-1:0] PROG_ADDR_OUT,
    input wire logic [`IFP_WORD_W-1:0] PROG_DATA_IN,
    input wire logic [7:0] PROG_BYTE_IN,
    // Core state
    input wire logic [7:0] WORKING_REG_IN,
    input wire logic SKIP_IN,
    // Data memory timing
    output logic DATA_READ_OUT,
    output logic DATA_WRITE_OUT,
    // Pipeline view
    output logic [3:0] PHASE_OUT,
    output logic [`IFP_WORD_W-1:0] INSTR_OUT,
    output logic INSTR_VALID_OUT,
    output logic SECOND_WORD_OUT,
    output logic [11:0] LITERAL_OUT,
    output logic [`IFP_PC_W-1:0] PC_OUT,
    output logic [`IFP_PC_W-1:0] TABLE_PTR_OUT,
    output logic [7:0] TABLE_LATCH_OUT
);
    logic [3:0] phase;
    logic [`IFP_WORD_W-1:0] fetch_reg;
    logic fetch_valid_reg;
    logic [`IFP_WORD_W-1:0] instr_reg;
    logic exec_valid_reg;
    logic pend_two_reg;
    logic [7:0] first_hi_reg;
    logic [`IFP_PC_W-1:0] pc_reg;
    logic [`IFP_PC_W-1:0] pc_next;
    logic [`IFP_PC_W-1:0] table_pointer_reg;
    logic [7:0] table_latch_reg;
    logic [7:0] lit_lo_reg;
    logic load_pc;
    logic [`IFP_PC_W-1:0] target;
    logic is_second;
    logic [10:0] rel;

    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:8] == `IFP_OP_GOTO) ||
            (w[15:9] == `IFP_OP_CALL) ||
            (w[15:12] == `IFP_OP_MOVE_FILE) ||
            (w[15:6] == `IFP_OP_LOAD_SELECT);
    endfunction : is_two_word

    ifp_phase_gen u_phase (
        .clk_in(CLK_IN),
        .arst_n_in(ARST_N_IN),
        .phase_out(phase)
    );

    assign is_second = pend_two_reg &&
        (instr_reg[15:12] == `IFP_SECOND_NIBBLE);
    assign rel = instr_reg[10:0];

    always_comb begin
        load_pc = 1'b0;
        target = pc_reg;
        if (exec_valid_reg && is_second &&
            (first_hi_reg == `IFP_OP_GOTO ||
             first_hi_reg[7:1] == `IFP_OP_CALL)) begin
            load_pc = 1'b1;
            target = {instr_reg[11:0], lit_lo_reg, 1'b0};
        end else if (exec_valid_reg && !pend_two_reg &&
            instr_reg[15:11] == `IFP_OP_BRA) begin
            load_pc = 1'b1;
            target = pc_reg + {{9{rel[10]}}, rel, 1'b0};
        end else if (exec_valid_reg && !pend_two_reg &&
            instr_reg == `IFP_OP_ADD_WORK_PC) begin
            load_pc = 1'b1;
            target = {pc_reg[20:8], 8'h00} +
                {13'h0000, pc_reg[7:0] + WORKING_REG_IN};
        end
        pc_next = load_pc ? {target[20:1], 1'b0} : pc_reg + `IFP_PC_STEP;
    end

    // Low literal byte of a two-word instruction
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            lit_lo_reg <= 8'h00;
        end else if (phase[0] && !pend_two_reg && is_two_word(fetch_reg)) begin
            lit_lo_reg <= fetch_reg[7:0];
        end
    end

    // Program counter
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            pc_reg <= `IFP_PC_RESET;
        end else if (phase[3]) begin
            pc_reg <= pc_next;
        end
    end

    // Fetch stage
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            fetch_reg <= `IFP_NOP_WORD;
            fetch_valid_reg <= 1'b0;
        end else if (phase[3]) begin
            fetch_reg <= PROG_DATA_IN;
            fetch_valid_reg <= !load_pc;
        end
    end

    // Execute stage
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            instr_reg <= `IFP_NOP_WORD;
            exec_valid_reg <= 1'b0;
            pend_two_reg <= 1'b0;
            first_hi_reg <= 8'h00;
        end else if (phase[0]) begin
            instr_reg <= fetch_reg;
            exec_valid_reg <= fetch_valid_reg && !SKIP_IN;
            pend_two_reg <= exec_valid_reg && !pend_two_reg &&
                is_two_word(instr_reg);
            first_hi_reg <= instr_reg[15:8];
        end
    end

    // Table read
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            table_pointer_reg <= `IFP_PC_RESET;
            table_latch_reg <= 8'h00;
        end else if (phase[3] && exec_valid_reg &&
            instr_reg == {2'b00, `IFP_OP_TBLRD}) begin
            table_latch_reg <= PROG_BYTE_IN;
        end
    end

    // Outputs
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            PROG_ADDR_OUT <= `IFP_PC_RESET;
            DATA_READ_OUT <= 1'b0;
            DATA_WRITE_OUT <= 1'b0;
            PHASE_OUT <= 4'h0;
            INSTR_OUT <= `IFP_NOP_WORD;
            INSTR_VALID_OUT <= 1'b0;
            SECOND_WORD_OUT <= 1'b0;
            LITERAL_OUT <= 12'h000;
            PC_OUT <= `IFP_PC_RESET;
            TABLE_PTR_OUT <= `IFP_PC_RESET;
            TABLE_LATCH_OUT <= 8'h00;
        end else begin
            PROG_ADDR_OUT <= pc_reg;
            DATA_READ_OUT <= phase[1] && exec_valid_reg && !is_second;
            DATA_WRITE_OUT <= phase[3] && exec_valid_reg && !is_second;
            PHASE_OUT <= phase;
            INSTR_OUT <= instr_reg;
            INSTR_VALID_OUT <= exec_valid_reg;
            SECOND_WORD_OUT <= is_second;
            LITERAL_OUT <= instr_reg[11:0];
            PC_OUT <= pc_reg;
            TABLE_PTR_OUT <= table_pointer_reg;
            TABLE_LATCH_OUT <= table_latch_reg;
        end
    end
endmodule : ifp_fetch_top

// file: src/ifp_phase_gen.sv
// Purpose: Four-phase generator from the system clock
// Assumes: One clock, asynchronous active-low reset
// Notes: Outputs are one-hot registered phase flags
`timescale 1ns/1ps
`include "ifp_defs.svh"
module ifp_phase_gen
    import ifp_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Phases
    output logic [3:0] phase_out
);
    ifp_phase_type state_reg;
    ifp_phase_type state_next;

    always_comb begin
        unique case (state_reg)
            IFP_PH1: state_next = IFP_PH2;
            IFP_PH2: state_next = IFP_PH3;
            IFP_PH3: state_next = IFP_PH4;
            IFP_PH4: state_next = IFP_PH1;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= IFP_PH1;
            phase_out <= 4'h1;
        end else begin
            state_reg <= state_next;
            unique case (state_next)
                IFP_PH1: phase_out <= 4'h1;
                IFP_PH2: phase_out <= 4'h2;
                IFP_PH3: phase_out <= 4'h4;
                IFP_PH4: phase_out <= 4'h8;
            endcase
        end
    end
endmodule : ifp_phase_gen

// file: src/ifp_pkg.sv
// Purpose: Types for the instruction fetch pipeline
// Assumes: Constants come from ifp_defs.svh
// Notes: Phase enum is Gray coded along the phase sequence
package ifp_pkg;
    typedef enum logic [1:0] {
        IFP_PH1 = 2'h0,
        IFP_PH2 = 2'h1,
        IFP_PH3 = 2'h3,
        IFP_PH4 = 2'h2
    } ifp_phase_type;
endpackage : ifp_pkg
